// ### design/fsb_security_unlock.sv
//----------------------------------------------------------------------
// flash security and backdoor unlock
//----------------------------------------------------------------------
// Purpose: working protection/option registers, security state, backdoor key
// Assumes: nonvolatile image, source flags and erase events on ref_clk
// Notes: registers reached over classic Wishbone
//
// Notes on behaviour
// - each reset, copy stored protection and option bytes to working registers
// - backdoor compare key is eight bytes held in nonvolatile flash area
// - matching key disengages security only while key unlock enable is 1
// - key entry accepted only from user code running in secure memory
// - key presented through background debug accesses is always rejected
// - key unlock enable programmed 0 disables the backdoor entirely
// - without key, security lifts only after mass erase then blank check
`timescale 1ns/1ps
`default_nettype none
module fsb_security_unlock
    import fsb_pkg::*;
#(
    parameter int NKEY = KEY_BYTES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire fsb_nv_image_t nv_image,
    input wire fsb_source_t source,
    input wire fsb_erase_evt_t erase_evt,
    output logic [7:0] protection_working_reg,
    output logic [7:0] option_working_reg,
    output logic security_engaged
);

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    logic loaded;
    logic key_open;
    logic erased;
    logic blank_open;
    logic key_reject;
    logic [7:0] entered_key [NKEY];
    logic [NKEY-1:0] byte_match;
    logic key_match;
    logic sec_locked;
    logic key_unlock_enable;
    logic req;
    logic wr_commit;
    logic trusted;
    logic key_sel;
    logic [KEY_IDX_W-1:0] key_idx;
    logic [AW-1:0] key_off;
    logic compare_go;
    logic clr_reject;
    logic [31:0] next_dat;
    logic [7:0] status_byte;

    assign req = wb_cyc_i & wb_stb_i & loaded;
    assign wr_commit = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign trusted = source.cpu_secure_code & ~source.debug_access;
    assign key_sel = (wb_adr_i >= OFS_KEY0) && (wb_adr_i <= OFS_KEY_LAST)
                     && (wb_adr_i[1:0] == 2'h0);
    assign key_off = wb_adr_i - OFS_KEY0;
    assign key_idx = key_off[KEY_IDX_LSB +: KEY_IDX_W];
    assign compare_go = wr_commit && (wb_adr_i == OFS_CTRL)
                        && wb_dat_i[CTRL_COMPARE];
    assign clr_reject = wr_commit && (wb_adr_i == OFS_CTRL)
                        && wb_dat_i[CTRL_CLR_REJECT];
    assign sec_locked = (option_working_reg[OPT_SEC_LSB +: 2] != SEC_UNSECURED);
    assign key_unlock_enable = option_working_reg[OPT_KEY_UNLOCK_ENABLE_BIT];

    //------------------------------------------------------------------
    // key compare
    //------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NKEY; gi++)
        begin : g_cmp
            fsb_key_byte_cmp #(.W(8)) u_cmp (
                .entered(entered_key[gi]),
                .stored(nv_image.key[gi*8 +: 8]),
                .match(byte_match[gi])
            );
        end
    endgenerate
    assign key_match = &byte_match;

    //------------------------------------------------------------------
    // reset load of working registers
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded <= 1'b0;
            protection_working_reg <= PROT_RST;
            option_working_reg <= OPT_RST;
        end
        else if (!loaded)
        begin
            loaded <= 1'b1;
            protection_working_reg <= nv_image.prot;
            option_working_reg <= nv_image.opt;
        end
    end

    //------------------------------------------------------------------
    // key entry bytes
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NKEY; i++)
            begin
                entered_key[i] <= 8'h00;
            end
        end
        else if (wr_commit && key_sel && trusted)
        begin
            entered_key[key_idx] <= wb_dat_i[7:0];
        end
    end

    //------------------------------------------------------------------
    // backdoor release
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_open <= 1'b0;
        end
        else if (compare_go && trusted && key_unlock_enable && key_match)
        begin
            key_open <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_reject <= 1'b0;
        end
        else if (compare_go && !(trusted && key_unlock_enable && key_match))
        begin
            key_reject <= 1'b1;
        end
        else if (clr_reject)
        begin
            key_reject <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // erase and blank check release
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            erased <= 1'b0;
            blank_open <= 1'b0;
        end
        else
        begin
            if (erase_evt.mass_erase_done)
            begin
                erased <= 1'b1;
            end
            if (erase_evt.blank_check_ok && (erased || erase_evt.mass_erase_done))
            begin
                blank_open <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------------
    // security output
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            security_engaged <= 1'b1;
        end
        else
        begin
            security_engaged <= ~loaded | (sec_locked & ~key_open & ~blank_open);
        end
    end

    //------------------------------------------------------------------
    // wishbone slave
    //------------------------------------------------------------------
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[ST_SECURE] = security_engaged;
        status_byte[ST_KEY_OPEN] = key_open;
        status_byte[ST_ERASED] = erased;
        status_byte[ST_BLANK_OPEN] = blank_open;
        status_byte[ST_KEY_REJECT] = key_reject;
        status_byte[ST_LOADED] = loaded;
        next_dat = DAT_ZERO;
        case (wb_adr_i)
            OFS_PROT: next_dat[7:0] = protection_working_reg;
            OFS_OPT: next_dat[7:0] = option_working_reg;
            OFS_STATUS: next_dat[7:0] = status_byte;
            default: next_dat = DAT_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= DAT_ZERO;
        end
        else
        begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= (req & ~wb_ack_o & ~wb_we_i) ? next_dat : DAT_ZERO;
        end
    end

endmodule // fsb_security_unlock
`default_nettype wire

// ### design/fsb_pkg.sv
//----------------------------------------------------------------------
// package
//----------------------------------------------------------------------
// Purpose: constants and types for the flash security and backdoor block
// Assumes: 32-bit classic Wishbone register bus, byte-wide fields in low bits
// Notes: offsets are byte addresses of aligned words
package fsb_pkg;

    localparam int KEY_BYTES = 8;
    localparam int AW = 8;

    // register byte offsets
    localparam logic [AW-1:0] OFS_PROT = 8'h00;
    localparam logic [AW-1:0] OFS_OPT = 8'h04;
    localparam logic [AW-1:0] OFS_STATUS = 8'h08;
    localparam logic [AW-1:0] OFS_CTRL = 8'h0C;
    localparam logic [AW-1:0] OFS_KEY0 = 8'h10;
    localparam logic [AW-1:0] OFS_KEY_LAST = 8'h2C;
    localparam int KEY_IDX_LSB = 2;
    localparam int KEY_IDX_W = 3;

    // option byte fields
    localparam int OPT_KEY_UNLOCK_ENABLE_BIT = 7;
    localparam int OPT_SEC_LSB = 0;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;

    // status bits
    localparam int ST_SECURE = 0;
    localparam int ST_KEY_OPEN = 1;
    localparam int ST_ERASED = 2;
    localparam int ST_BLANK_OPEN = 3;
    localparam int ST_KEY_REJECT = 4;
    localparam int ST_LOADED = 5;

    // control bits
    localparam int CTRL_COMPARE = 0;
    localparam int CTRL_CLR_REJECT = 1;

    // reset values before the nonvolatile copy lands
    localparam logic [7:0] PROT_RST = 8'hFF;
    localparam logic [7:0] OPT_RST = 8'h00;
    localparam logic [31:0] DAT_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] prot;
        logic [7:0] opt;
        logic [KEY_BYTES*8-1:0] key;
    } fsb_nv_image_t;

    typedef struct packed {
        logic cpu_secure_code;
        logic debug_access;
    } fsb_source_t;

    typedef struct packed {
        logic mass_erase_done;
        logic blank_check_ok;
    } fsb_erase_evt_t;

endpackage : fsb_pkg

// ### design/fsb_key_byte_cmp.sv
//----------------------------------------------------------------------
// key byte compare
//----------------------------------------------------------------------
// Purpose: compare one entered key byte with one stored key byte
// Assumes: both bytes on the same clock
// Notes: combinational
`timescale 1ns/1ps
`default_nettype none
module fsb_key_byte_cmp
    import fsb_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic [W-1:0] entered,
    input wire logic [W-1:0] stored,
    output logic match
);
    assign match = (entered == stored);
endmodule // fsb_key_byte_cmp
`default_nettype wire

// ### testbench/fsb_security_unlock_assertions.sv
//----------------------------------------------------------------------
// security unlock checker
//----------------------------------------------------------------------
// Purpose: bus and security checks on the security unlock ports
// Assumes: one clock, async active-low reset
// Notes: bound into the design below
`timescale 1ns/1ps
`default_nettype none
module fsb_sec_checker
    import fsb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire fsb_source_t source,
    input wire fsb_nv_image_t nv_image,
    input wire fsb_erase_evt_t erase_evt,
    input wire logic [7:0] protection_working_reg,
    input wire logic [7:0] option_working_reg,
    input wire logic security_engaged
);
    logic cmd_go;
    logic trusted;
    logic erased;
    assign cmd_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == OFS_CTRL
        && wb_dat_i[CTRL_COMPARE];
    assign trusted = source.cpu_secure_code && !source.debug_access;
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            erased <= 1'b0;
        else if (erase_evt.mass_erase_done)
            erased <= 1'b1;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_ack_one;
        wb_cyc_i && wb_stb_i && !wb_ack_o && $past(rst_n) |=> wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack missing");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == DAT_ZERO;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data not zero");
    property p_load;
        !$past(rst_n) |=> {protection_working_reg, option_working_reg}
            == {nv_image.prot, nv_image.opt};
    endproperty
    a_load: assert property (p_load) else $error("working regs not loaded");
    property p_sec_reset;
        !$past(rst_n) |=> ##1 security_engaged == (option_working_reg[1:0] != SEC_UNSECURED);
    endproperty
    a_sec_reset: assert property (p_sec_reset) else $error("bad lock after reset");
    property p_sec_hold;
        !$past(rst_n) |=> security_engaged;
    endproperty
    a_sec_hold: assert property (p_sec_hold) else $error("lock dropped during load");
    property p_untrusted;
        cmd_go && !trusted |=> $stable(security_engaged)[*3];
    endproperty
    a_untrusted: assert property (p_untrusted) else $error("untrusted unlock");
    property p_keyoff;
        cmd_go && !option_working_reg[OPT_KEY_UNLOCK_ENABLE_BIT] |=> $stable(security_engaged)[*3];
    endproperty
    a_keyoff: assert property (p_keyoff) else $error("unlock with key off");
    property p_fall_cause;
        $fell(security_engaged) && $past(rst_n, 3) |-> option_working_reg[OPT_KEY_UNLOCK_ENABLE_BIT]
            || erased;
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("release without cause");
    property p_blank;
        erase_evt.blank_check_ok && (erased || erase_evt.mass_erase_done)
            |=> ##1 !security_engaged;
    endproperty
    a_blank: assert property (p_blank) else $error("no release after erase");
endmodule // fsb_sec_checker
bind fsb_security_unlock fsb_sec_checker fsb_sec_checker_inst (.ref_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .source, .nv_image,
    .erase_evt, .protection_working_reg, .option_working_reg, .security_engaged);
`default_nettype wire

// ### testbench/fsb_flash_model.sv
//----------------------------------------------------------------------
// flash model
//----------------------------------------------------------------------
// Purpose: flash image and erase sequencer seen by the block
// Assumes: erase_req is a one-cycle pulse
// Notes: key and protection byte are parameters
`timescale 1ns/1ps
`default_nettype none
module fsb_flash_model
    import fsb_pkg::*;
#(
    parameter logic [63:0] KEY = 64'h0,
    parameter logic [7:0] PROT = 8'h00
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] opt_byte,
    input wire logic erase_req,
    output fsb_nv_image_t nv_image,
    output fsb_erase_evt_t erase_evt
);
    logic [1:0] phase;
    assign nv_image = '{prot: PROT, opt: opt_byte, key: KEY};
    always_ff @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            phase <= 2'h0;
        else
            phase <= erase_req ? 2'h1 : (phase == 2'h1 ? 2'h2 : 2'h0);
    // mass erase first, blank check next cycle
    assign erase_evt = '{mass_erase_done: phase == 2'h1, blank_check_ok: phase == 2'h2};
endmodule // fsb_flash_model
`default_nettype wire

// ### testbench/testbench.sv
//----------------------------------------------------------------------
// testbench
//----------------------------------------------------------------------
// Purpose: register-level tests of the security unlock block
// Assumes: one-cycle ack, status bit map of the package
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fsb_pkg::*;
;
    localparam logic [63:0] KEY = 64'h1357_9BDF_2468_ACE0;
    localparam logic [7:0] PROT = 8'h5A;
    logic ref_clk, rst_n, cyc, stb, we, ack, erase_req, sec;
    logic [AW-1:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [7:0] opt, prt, opr;
    fsb_source_t src;
    fsb_nv_image_t nv;
    fsb_erase_evt_t evt;
    int err_total, comparisons;
    fsb_security_unlock fsb_security_unlock_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .nv_image(nv), .source(src),
        .erase_evt(evt), .protection_working_reg(prt), .option_working_reg(opr),
        .security_engaged(sec));
    fsb_flash_model #(.KEY(KEY), .PROT(PROT)) fsb_flash_model_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .opt_byte(opt), .erase_req(erase_req), .nv_image(nv), .erase_evt(evt));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            wrap_up;
        end
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, DAT_ZERO);
        check(q, exp);
    endtask
    task automatic rst(input logic [7:0] o);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        opt <= o;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic key(input logic [7:0] flip);
        for (int i = 0; i < 8; i++)
            bus(1'b1, OFS_KEY0 + AW'(4 * i), {24'h0, KEY[8*i +: 8] ^ (i == 7 ? flip : 8'h00)});
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic wrap_up;
        $display("comparisons=%0d errors=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        #50000;
        err_total++;
        wrap_up;
    end
    initial
    begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        wdat = '0;
        erase_req = 1'b0;
        opt = 8'h80;
        src = '0;
        err_total = 0;
        comparisons = 0;
        rst(8'h80);
        rd(OFS_PROT, {24'h0, PROT});
        rd(OFS_OPT, 32'h80);
        check({16'h0, prt, opr}, {16'h0, PROT, 8'h80});
        rd(OFS_STATUS, 32'h21);
        rd(8'h30, DAT_ZERO);
        $display("test reset done");
        for (int s = 0; s < 4; s++)
        begin
            if (s == 2) continue;
            src <= fsb_source_t'(s[1:0]);
            key(8'h00);
            rd(OFS_STATUS, 32'h31);
            src <= fsb_source_t'(2'h2);
            bus(1'b1, OFS_CTRL, 32'h2);
        end
        $display("test source done");
        key(8'h01);
        rd(OFS_STATUS, 32'h31);
        bus(1'b1, OFS_CTRL, 32'h2);
        key(8'h00);
        rd(OFS_STATUS, 32'h22);
        check({31'h0, sec}, 32'h0);
        rst(8'h80);
        rd(OFS_STATUS, 32'h21);
        $display("test key done");
        rst(8'h00);
        key(8'h00);
        rd(OFS_STATUS, 32'h31);
        @(posedge ref_clk);
        erase_req <= 1'b1;
        @(posedge ref_clk);
        erase_req <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(OFS_STATUS, 32'h3C);
        check({31'h0, sec}, 32'h0);
        rst(8'h02);
        rd(OFS_STATUS, 32'h20);
        check({31'h0, sec}, 32'h0);
        $display("test erase done");
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
